//--- hw/halfword_order.sv
// Splits transmit DWORDs into half-words and assembles received half-words into DWORDs.
// Assumes the network side consumes one half-word per cycle while TX_WORD_VALID is high.
`default_nettype none

module halfword_order (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [host_port_pkg::DWORD_W-1:0] TX_DWORD,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic [host_port_pkg::HALF_W-1:0] TX_WORD,
    output logic TX_WORD_VALID,
    input wire logic [host_port_pkg::HALF_W-1:0] RX_WORD,
    input wire logic RX_WORD_VALID,
    output logic [host_port_pkg::DWORD_W-1:0] RX_DWORD,
    output logic RX_DWORD_VALID
);
    import host_port_pkg::*;

    logic [HALF_W-1:0] tx_high_ff;
    logic tx_second_ff;
    logic rx_second_ff;
    logic [HALF_W-1:0] rx_low_ff;

    // The low-order word always leaves first; the high half waits one cycle.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            TX_READY <= 1'b0;
            TX_WORD <= HALF_RESET;
            TX_WORD_VALID <= 1'b0;
            tx_high_ff <= HALF_RESET;
            tx_second_ff <= 1'b0;
        end else if (tx_second_ff) begin
            TX_WORD <= tx_high_ff; // RQ15
            TX_WORD_VALID <= 1'b1;
            tx_second_ff <= 1'b0;
            TX_READY <= 1'b1;
        end else if (TX_VALID && TX_READY) begin
            TX_WORD <= TX_DWORD[HALF_W-1:0]; // RQ15
            tx_high_ff <= TX_DWORD[DWORD_W-1:HALF_W];
            TX_WORD_VALID <= 1'b1;
            tx_second_ff <= 1'b1;
            TX_READY <= 1'b0;
        end else begin
            TX_WORD_VALID <= 1'b0;
            TX_READY <= 1'b1;
        end
    end

    // The first half-word received is the low-order word of the DWORD.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rx_second_ff <= 1'b0;
            rx_low_ff <= HALF_RESET;
            RX_DWORD <= DWORD_RESET;
            RX_DWORD_VALID <= 1'b0;
        end else begin
            RX_DWORD_VALID <= 1'b0;
            if (RX_WORD_VALID) begin
                if (!rx_second_ff) begin
                    rx_low_ff <= RX_WORD; // RQ15
                    rx_second_ff <= 1'b1;
                end else begin
                    RX_DWORD <= {RX_WORD, rx_low_ff}; // RQ15
                    RX_DWORD_VALID <= 1'b1;
                    rx_second_ff <= 1'b0;
                end
            end
        end
    end

endmodule : halfword_order

`default_nettype wire

//--- hw/host_bus_port.sv
// Host parallel bus port: 32-bit native or strapped 16-bit mode with half-word pairing and word swap.
// Assumes asynchronous host pins, an internal register/FIFO port answering within the cycle CORE_RD stands,
// and an internal word swap register value presented on WORD_SWAP_VALUE.
`default_nettype none

// How it works
// RQ1: The bus width strap pin is caught after reset release and its width shows in bit 2 of the hardware config word.
// RQ2: In 16-bit mode the host writes a DWORD as two back-to-back half-word writes.
// RQ3: The host holds the DWORD address bits steady across a write pair.
// RQ4: The two write halves are taken in either order as long as the second targets the other half.
// RQ5: A second write to the half already written is dropped.
// RQ6: In 16-bit mode the host reads a DWORD as two back-to-back half-word reads.
// RQ7: The host holds the DWORD address bits steady across a read pair.
// RQ8: The two read halves are served in either order as long as the second reads the other half.
// RQ9: Reading the same half twice returns invalid data and clears the read pairing so the next read starts anew.
// RQ10: In 16-bit mode the upper data lines are never driven.
// RQ11: Word swap acts only in 16-bit mode, for every register and FIFO access through this port.
// RQ12: In 32-bit mode word swap is ignored and the data lanes map straight through.
// RQ13: Without all-ones swap, word select 0 maps the low data lanes to bytes 1:0 and word select 1 to bytes 3:2.
// RQ14: With all-ones swap, word select 0 maps the low data lanes to bytes 3:2 and word select 1 to bytes 1:0.
// RQ15: Transmit sends the low-order word first and receive fills the low-order word first.
// RQ16: Reset clears both write and read pairing so the next access is a first half.
module host_bus_port (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic BUS_WIDTH_STRAP_PIN,
    input wire logic HOST_CS_N,
    input wire logic HOST_WR_N,
    input wire logic HOST_RD_N,
    input wire logic [host_port_pkg::ADDR_MSB:1] HOST_ADDR,
    input wire logic [host_port_pkg::DWORD_W-1:0] HOST_D_IN,
    output logic [host_port_pkg::DWORD_W-1:0] HOST_D_OUT,
    output logic HOST_D_LO_OE_N,
    output logic HOST_D_HI_OE_N,
    input wire logic [host_port_pkg::DWORD_W-1:0] WORD_SWAP_VALUE,
    output logic [host_port_pkg::DWORD_W-1:0] HARDWARE_CONFIG_REGISTER,
    output logic BUS_WIDTH_32,
    output logic CORE_WR,
    output logic CORE_RD,
    output logic [host_port_pkg::ADDR_MSB:2] CORE_ADDR,
    output logic [host_port_pkg::DWORD_W-1:0] CORE_WDATA,
    input wire logic [host_port_pkg::DWORD_W-1:0] CORE_RDATA,
    input wire logic [host_port_pkg::DWORD_W-1:0] TX_DWORD,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic [host_port_pkg::HALF_W-1:0] TX_WORD,
    output logic TX_WORD_VALID,
    input wire logic [host_port_pkg::HALF_W-1:0] RX_WORD,
    input wire logic RX_WORD_VALID,
    output logic [host_port_pkg::DWORD_W-1:0] RX_DWORD,
    output logic RX_DWORD_VALID
);
    import host_port_pkg::*;

    logic strap_s1_ff;
    logic strap_s2_ff;
    logic strap_taken_ff;
    logic [2:0] cs_n_ff;
    logic [2:0] wr_n_ff;
    logic [2:0] rd_n_ff;
    logic [ADDR_MSB:1] addr_s1_ff;
    logic [ADDR_MSB:1] addr_s2_ff;
    logic [DWORD_W-1:0] din_s1_ff;
    logic [DWORD_W-1:0] din_s2_ff;

    logic wr_have_ff;
    logic wr_high_ff;
    logic [HALF_W-1:0] wr_half_ff;
    logic rd_have_ff;
    logic rd_high_ff;
    logic [DWORD_W-1:0] rd_dword_ff;
    rd_state_t rd_state_ff;
    rd_state_t nxt_rd_state;

    logic wr_active;
    logic wr_active_d;
    logic rd_active;
    logic rd_active_d;
    logic wr_start;
    logic rd_start;
    logic rd_end;
    logic swap_on;
    logic phys_high;
    logic rd_need_fetch;

    // The strap and the host pins come from outside this clock; each passes two flops first.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
            cs_n_ff <= 3'h7;
            wr_n_ff <= 3'h7;
            rd_n_ff <= 3'h7;
            addr_s1_ff <= HOST_ADDR_RESET;
            addr_s2_ff <= HOST_ADDR_RESET;
            din_s1_ff <= DWORD_RESET;
            din_s2_ff <= DWORD_RESET;
        end else begin
            strap_s1_ff <= BUS_WIDTH_STRAP_PIN;
            strap_s2_ff <= strap_s1_ff;
            cs_n_ff <= {cs_n_ff[1:0], HOST_CS_N};
            wr_n_ff <= {wr_n_ff[1:0], HOST_WR_N};
            rd_n_ff <= {rd_n_ff[1:0], HOST_RD_N};
            addr_s1_ff <= HOST_ADDR;
            addr_s2_ff <= addr_s1_ff;
            din_s1_ff <= HOST_D_IN;
            din_s2_ff <= din_s1_ff;
        end
    end

    // The width is caught once, on the third edge after release, when the pin has crossed both flops.
    // An earlier capture would read the reset value still held in the synchroniser.
    logic [1:0] strap_wait_ff;
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            strap_wait_ff <= 2'h0;
            strap_taken_ff <= 1'b0;
            BUS_WIDTH_32 <= 1'b0;
            HARDWARE_CONFIG_REGISTER <= DWORD_RESET;
        end else begin
            strap_wait_ff <= {strap_wait_ff[0], 1'b1};
            if (strap_wait_ff[1] && !strap_taken_ff) begin
                strap_taken_ff <= 1'b1;
                BUS_WIDTH_32 <= strap_s2_ff; // RQ1
                HARDWARE_CONFIG_REGISTER[HWCFG_BUS32_BIT] <= strap_s2_ff; // RQ1
            end
        end
    end

    assign wr_active = !cs_n_ff[1] && !wr_n_ff[1];
    assign wr_active_d = !cs_n_ff[2] && !wr_n_ff[2];
    assign rd_active = !cs_n_ff[1] && !rd_n_ff[1];
    assign rd_active_d = !cs_n_ff[2] && !rd_n_ff[2];
    assign wr_start = strap_taken_ff && wr_active && !wr_active_d;
    assign rd_start = strap_taken_ff && rd_active && !rd_active_d;
    assign rd_end = !rd_active;

    assign swap_on = !BUS_WIDTH_32 && (WORD_SWAP_VALUE == SWAP_ALL_ONES); // RQ11 RQ12
    assign phys_high = addr_s2_ff[WORD_SEL_BIT] ^ swap_on; // RQ13 RQ14
    assign rd_need_fetch = BUS_WIDTH_32 || !rd_have_ff;

    // Writes: 32-bit mode passes straight through, 16-bit mode pairs two halves into one DWORD.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            wr_have_ff <= 1'b0; // RQ16
            wr_high_ff <= 1'b0;
            wr_half_ff <= HALF_RESET;
            CORE_WR <= 1'b0;
            CORE_WDATA <= DWORD_RESET;
        end else begin
            CORE_WR <= 1'b0;
            if (wr_start) begin
                if (BUS_WIDTH_32) begin
                    CORE_WDATA <= din_s2_ff; // RQ12
                    CORE_WR <= 1'b1;
                end else if (!wr_have_ff) begin
                    wr_half_ff <= din_s2_ff[HALF_W-1:0];
                    wr_high_ff <= phys_high; // RQ4
                    wr_have_ff <= 1'b1;
                end else if (phys_high != wr_high_ff) begin
                    CORE_WDATA <= phys_high ? {din_s2_ff[HALF_W-1:0], wr_half_ff}
                                            : {wr_half_ff, din_s2_ff[HALF_W-1:0]}; // RQ4 RQ13 RQ14
                    CORE_WR <= 1'b1;
                    wr_have_ff <= 1'b0;
                end
                // A repeat to the half already held is dropped and the pair stays open. RQ5
            end
        end
    end

    // The address is taken at each 32-bit access, first write half and fetching read; a second half reuses the held DWORD address.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            CORE_ADDR <= CORE_ADDR_RESET;
        end else if ((wr_start && (BUS_WIDTH_32 || !wr_have_ff)) || (rd_start && rd_need_fetch)) begin
            CORE_ADDR <= addr_s2_ff[ADDR_MSB:2];
        end
    end

    always_comb begin
        nxt_rd_state = rd_state_ff;
        case (rd_state_ff)
            RD_IDLE: begin
                if (rd_start) begin
                    nxt_rd_state = rd_need_fetch ? RD_FETCH : RD_DRIVE;
                end
            end
            RD_FETCH: begin
                nxt_rd_state = RD_DRIVE;
            end
            RD_DRIVE: begin
                if (rd_end) begin
                    nxt_rd_state = RD_IDLE;
                end
            end
            default: begin
                nxt_rd_state = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rd_state_ff <= RD_IDLE;
        end else begin
            rd_state_ff <= nxt_rd_state;
        end
    end

    // Reads: the first half fetches the DWORD, the second half is served from the held copy.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rd_have_ff <= 1'b0; // RQ16
            rd_high_ff <= 1'b0;
            rd_dword_ff <= DWORD_RESET;
            CORE_RD <= 1'b0;
        end else begin
            CORE_RD <= 1'b0;
            if (rd_state_ff == RD_IDLE && rd_start) begin
                if (rd_need_fetch) begin
                    CORE_RD <= 1'b1;
                    rd_high_ff <= phys_high;
                    rd_have_ff <= !BUS_WIDTH_32;
                end else begin
                    // Either the other half completes the pair, or a repeat voids it. RQ8 RQ9
                    rd_have_ff <= 1'b0;
                end
            end
            if (rd_state_ff == RD_FETCH) begin
                rd_dword_ff <= CORE_RDATA;
            end
        end
    end

    // Data lanes: upper lanes are driven only in 32-bit mode; the low lanes carry the mapped half.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            HOST_D_OUT <= DWORD_RESET;
            HOST_D_LO_OE_N <= 1'b1;
            HOST_D_HI_OE_N <= 1'b1;
        end else begin
            if (rd_state_ff == RD_FETCH) begin
                if (BUS_WIDTH_32) begin
                    HOST_D_OUT <= CORE_RDATA; // RQ12
                end else begin
                    HOST_D_OUT <= {HALF_RESET, phys_high ? CORE_RDATA[DWORD_W-1:HALF_W]
                                                         : CORE_RDATA[HALF_W-1:0]}; // RQ13 RQ14
                end
            end else if (rd_state_ff == RD_IDLE && rd_start && !rd_need_fetch) begin
                // A repeat of the held half returns the same half again; the host must treat it as void.
                HOST_D_OUT <= {HALF_RESET, phys_high ? rd_dword_ff[DWORD_W-1:HALF_W]
                                                     : rd_dword_ff[HALF_W-1:0]}; // RQ8 RQ9
            end
            HOST_D_LO_OE_N <= !(nxt_rd_state == RD_DRIVE);
            HOST_D_HI_OE_N <= !(nxt_rd_state == RD_DRIVE && BUS_WIDTH_32); // RQ10
        end
    end

    halfword_order u_order (
        .SYS_CLK(SYS_CLK),
        .NRST(NRST),
        .TX_DWORD(TX_DWORD),
        .TX_VALID(TX_VALID),
        .TX_READY(TX_READY),
        .TX_WORD(TX_WORD),
        .TX_WORD_VALID(TX_WORD_VALID),
        .RX_WORD(RX_WORD),
        .RX_WORD_VALID(RX_WORD_VALID),
        .RX_DWORD(RX_DWORD),
        .RX_DWORD_VALID(RX_DWORD_VALID)
    );

endmodule : host_bus_port

`default_nettype wire

//--- hw/host_port_pkg.sv
// Shared constants for the host bus port: widths, field positions and reset values.
// Assumes a single 200 MHz clock domain and a synchronous active-low reset.
`default_nettype none

package host_port_pkg;

    localparam int DWORD_W = 32;
    localparam int HALF_W = 16;
    localparam int ADDR_MSB = 7;
    localparam int WORD_SEL_BIT = 1;
    localparam int HWCFG_BUS32_BIT = 2;
    localparam logic [31:0] SWAP_ALL_ONES = 32'hffffffff;
    localparam logic [31:0] DWORD_RESET = 32'h00000000;
    localparam logic [15:0] HALF_RESET = 16'h0000;
    localparam logic [ADDR_MSB:2] CORE_ADDR_RESET = 6'h00;
    localparam logic [ADDR_MSB:1] HOST_ADDR_RESET = 7'h00;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_FETCH = 2'b01,
        RD_DRIVE = 2'b11
    } rd_state_t;

endpackage : host_port_pkg

`default_nettype wire

//--- verification/host_bus_port_asserts.sv
// Concurrent checks on the host bus port, bound to every host_bus_port instance.
// Assumes one clock domain and a synchronous active-low reset.
`default_nettype none

module host_bus_port_chk (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic HOST_WR_N,
    input wire logic HOST_RD_N,
    input wire logic [host_port_pkg::DWORD_W-1:0] HOST_D_OUT,
    input wire logic HOST_D_LO_OE_N,
    input wire logic HOST_D_HI_OE_N,
    input wire logic [host_port_pkg::DWORD_W-1:0] HARDWARE_CONFIG_REGISTER,
    input wire logic BUS_WIDTH_32,
    input wire logic CORE_WR,
    input wire logic CORE_RD,
    input wire logic [host_port_pkg::DWORD_W-1:0] TX_DWORD,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic [host_port_pkg::HALF_W-1:0] TX_WORD,
    input wire logic TX_WORD_VALID
);
    import host_port_pkg::*;

    logic [31:0] tx_hold_ff;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    // The accepted word is kept so both halves can be compared after the input moves on.
    always_ff @(posedge SYS_CLK) begin
        if (TX_VALID && TX_READY) begin
            tx_hold_ff <= TX_DWORD;
        end
    end

    chk_cfg_width: assert property (HARDWARE_CONFIG_REGISTER == {29'h0, BUS_WIDTH_32, 2'h0})
        else $error("config word does not match bus width");
    chk_hi_undriven: assert property (!BUS_WIDTH_32 |-> HOST_D_HI_OE_N && HOST_D_OUT[31:16] == 16'h0000)
        else $error("upper lanes driven in 16-bit mode");
    chk_lanes_wide: assert property (BUS_WIDTH_32 && !HOST_D_LO_OE_N |-> !HOST_D_HI_OE_N)
        else $error("upper lanes not driven in 32-bit read");
    chk_rd_fetch: assert property (CORE_RD |=> !HOST_D_LO_OE_N)
        else $error("read data not presented after fetch");
    chk_rd_idle: assert property (HOST_RD_N [*6] |-> !CORE_RD)
        else $error("fetch without a read strobe");
    chk_wr_quiet: assert property (HOST_WR_N [*6] |-> !CORE_WR)
        else $error("write without a write strobe");
    chk_oe_release: assert property (HOST_RD_N [*5] |-> HOST_D_LO_OE_N && HOST_D_HI_OE_N)
        else $error("data lanes still driven after read");
    chk_tx_order: assert property (TX_VALID && TX_READY |=> (TX_WORD_VALID && TX_WORD == tx_hold_ff[15:0])
        ##1 (TX_WORD_VALID && TX_WORD == tx_hold_ff[31:16]))
        else $error("transmit half order wrong");
    chk_tx_busy: assert property (TX_VALID && TX_READY |=> !TX_READY ##1 TX_READY)
        else $error("transmit ready during split");
endmodule : host_bus_port_chk

bind host_bus_port host_bus_port_chk u_chk (.SYS_CLK, .NRST, .HOST_WR_N, .HOST_RD_N, .HOST_D_OUT, .HOST_D_LO_OE_N,
    .HOST_D_HI_OE_N, .HARDWARE_CONFIG_REGISTER, .BUS_WIDTH_32, .CORE_WR, .CORE_RD, .TX_DWORD, .TX_VALID, .TX_READY,
    .TX_WORD, .TX_WORD_VALID);

`default_nettype wire

//--- verification/host_bus_width_word_swap_test.sv
// Self-checking bench for host_bus_port in both bus widths, with the core store model.
// Assumes the checker is bound to the port.
`default_nettype none

module host_bus_width_word_swap_test;
    timeunit 1ns;
    timeprecision 1ps;
    import host_port_pkg::*;

    logic SYS_CLK, NRST, BUS_WIDTH_STRAP_PIN, HOST_CS_N, HOST_WR_N, HOST_RD_N, TX_VALID, RX_WORD_VALID;
    logic HOST_D_LO_OE_N, HOST_D_HI_OE_N, BUS_WIDTH_32, CORE_WR, CORE_RD, TX_READY, TX_WORD_VALID, RX_DWORD_VALID;
    logic [7:1] HOST_ADDR;
    logic [7:2] CORE_ADDR;
    logic [15:0] RX_WORD, TX_WORD;
    logic [31:0] HOST_D_IN, WORD_SWAP_VALUE, TX_DWORD, HOST_D_OUT, HARDWARE_CONFIG_REGISTER, CORE_WDATA, CORE_RDATA;
    logic [31:0] RX_DWORD, wd, q;
    logic [7:2] wa;
    int err_total = 0, num_checks = 0, wrc = 0, rdc = 0, c;

    host_bus_port u_dut (
        .SYS_CLK(SYS_CLK),
        .NRST(NRST),
        .BUS_WIDTH_STRAP_PIN(BUS_WIDTH_STRAP_PIN),
        .HOST_CS_N(HOST_CS_N),
        .HOST_WR_N(HOST_WR_N),
        .HOST_RD_N(HOST_RD_N),
        .HOST_ADDR(HOST_ADDR),
        .HOST_D_IN(HOST_D_IN),
        .HOST_D_OUT(HOST_D_OUT),
        .HOST_D_LO_OE_N(HOST_D_LO_OE_N),
        .HOST_D_HI_OE_N(HOST_D_HI_OE_N),
        .WORD_SWAP_VALUE(WORD_SWAP_VALUE),
        .HARDWARE_CONFIG_REGISTER(HARDWARE_CONFIG_REGISTER),
        .BUS_WIDTH_32(BUS_WIDTH_32),
        .CORE_WR(CORE_WR),
        .CORE_RD(CORE_RD),
        .CORE_ADDR(CORE_ADDR),
        .CORE_WDATA(CORE_WDATA),
        .CORE_RDATA(CORE_RDATA),
        .TX_DWORD(TX_DWORD),
        .TX_VALID(TX_VALID),
        .TX_READY(TX_READY),
        .TX_WORD(TX_WORD),
        .TX_WORD_VALID(TX_WORD_VALID),
        .RX_WORD(RX_WORD),
        .RX_WORD_VALID(RX_WORD_VALID),
        .RX_DWORD(RX_DWORD),
        .RX_DWORD_VALID(RX_DWORD_VALID)
    );
    host_core_model u_core (
        .SYS_CLK(SYS_CLK),
        .CORE_WR(CORE_WR),
        .CORE_RD(CORE_RD),
        .CORE_ADDR(CORE_ADDR),
        .CORE_WDATA(CORE_WDATA),
        .CORE_RDATA(CORE_RDATA)
    );

    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end

    always @(posedge SYS_CLK) begin
        if (CORE_WR === 1'b1) begin
            wrc++;
            wd = CORE_WDATA;
            wa = CORE_ADDR;
        end
        if (CORE_RD === 1'b1) rdc++;
    end

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rst(input logic s);
        BUS_WIDTH_STRAP_PIN <= s;
        NRST <= 1'b0;
        repeat (6) @(posedge SYS_CLK);
        NRST <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
    endtask : rst

    // Address and data settle three cycles ahead of the strobe; a read holds it until the lanes are driven.
    task automatic acc(input logic wr, input logic [7:1] a, input logic [31:0] d);
        int n;
        @(posedge SYS_CLK);
        HOST_ADDR <= a;
        HOST_D_IN <= wr ? d : ~d;
        repeat (3) @(posedge SYS_CLK);
        HOST_CS_N <= 1'b0;
        if (wr) HOST_WR_N <= 1'b0;
        else HOST_RD_N <= 1'b0;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (n < 12 && (wr ? n < 8 : HOST_D_LO_OE_N !== 1'b0));
        q = HOST_D_OUT;
        if (!wr && n >= 12) begin
            err_total++;
            test_done();
        end
        HOST_CS_N <= 1'b1;
        HOST_WR_N <= 1'b1;
        HOST_RD_N <= 1'b1;
        HOST_D_IN <= ~HOST_D_IN;
        repeat (5) @(posedge SYS_CLK);
    endtask : acc

    task automatic t_bus32();
        rst(1'b1);
        chk(HARDWARE_CONFIG_REGISTER, 32'h00000004);
        WORD_SWAP_VALUE <= SWAP_ALL_ONES;
        acc(1'b1, 7'h08, 32'h89abcdef);
        chk(wd, 32'h89abcdef);
        chk(wa, 6'h04);
        acc(1'b0, 7'h08, 32'h0);
        chk(q, 32'h89abcdef);
        $display("t_bus32 done");
    endtask : t_bus32

    task automatic t_wr16();
        rst(1'b0);
        chk(HARDWARE_CONFIG_REGISTER, 32'h00000000);
        WORD_SWAP_VALUE <= 32'h00000000;
        c = wrc;
        acc(1'b1, 7'h0a, 32'h1234);
        acc(1'b1, 7'h0b, 32'habcd);
        chk(wd, 32'habcd1234);
        chk(wa, 6'h05);
        WORD_SWAP_VALUE <= SWAP_ALL_ONES;
        acc(1'b1, 7'h0d, 32'h5555);
        acc(1'b1, 7'h0c, 32'h6666);
        chk(wd, 32'h66665555);
        chk(wrc - c, 2);
        $display("t_wr16 done");
    endtask : t_wr16

    task automatic t_wr_repeat();
        WORD_SWAP_VALUE <= 32'h00000000;
        c = wrc;
        acc(1'b1, 7'h0e, 32'h1111);
        acc(1'b1, 7'h0e, 32'h2222);
        chk(wrc - c, 0);
        acc(1'b1, 7'h0f, 32'h3333);
        chk(wd, 32'h33331111);
        acc(1'b1, 7'h10, 32'h7777);
        rst(1'b0);
        c = wrc;
        acc(1'b1, 7'h11, 32'h8888);
        chk(wrc - c, 0);
        acc(1'b1, 7'h10, 32'h9999);
        chk(wd, 32'h88889999);
        $display("t_wr_repeat done");
    endtask : t_wr_repeat

    task automatic t_rd16();
        c = rdc;
        acc(1'b0, 7'h0b, 32'h0);
        chk(q, 32'h0000abcd);
        acc(1'b0, 7'h0a, 32'h0);
        chk(q, 32'h00001234);
        chk(rdc - c, 1);
        WORD_SWAP_VALUE <= SWAP_ALL_ONES;
        acc(1'b0, 7'h0a, 32'h0);
        chk(q, 32'h0000abcd);
        acc(1'b0, 7'h0b, 32'h0);
        chk(q, 32'h00001234);
        c = rdc;
        acc(1'b0, 7'h0a, 32'h0);
        acc(1'b0, 7'h0a, 32'h0);
        chk(rdc - c, 1);
        acc(1'b0, 7'h0b, 32'h0);
        chk(rdc - c, 2);
        chk(q, 32'h00001234);
        $display("t_rd16 done");
    endtask : t_rd16

    task automatic t_txrx();
        int n;
        n = 0;
        while (TX_READY !== 1'b1 && n < 10) begin
            @(posedge SYS_CLK);
            n++;
        end
        if (TX_READY !== 1'b1) begin
            err_total++;
            test_done();
        end
        TX_DWORD <= 32'hbeef0042;
        TX_VALID <= 1'b1;
        @(posedge SYS_CLK);
        TX_VALID <= 1'b0;
        @(posedge SYS_CLK);
        chk({TX_WORD_VALID, TX_WORD}, 17'h10042);
        @(posedge SYS_CLK);
        chk({TX_WORD_VALID, TX_WORD}, 17'h1beef);
        RX_WORD <= 16'h0011;
        RX_WORD_VALID <= 1'b1;
        @(posedge SYS_CLK);
        RX_WORD <= 16'h0022;
        @(posedge SYS_CLK);
        RX_WORD_VALID <= 1'b0;
        RX_WORD <= 16'hffdd;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (RX_DWORD_VALID !== 1'b1 && n < 10);
        if (RX_DWORD_VALID !== 1'b1) begin
            err_total++;
            test_done();
        end
        chk(RX_DWORD, 32'h00220011);
        $display("t_txrx done");
    endtask : t_txrx

    initial begin
        NRST = 1'b0;
        BUS_WIDTH_STRAP_PIN = 1'b1;
        HOST_CS_N = 1'b1;
        HOST_WR_N = 1'b1;
        HOST_RD_N = 1'b1;
        HOST_ADDR = 7'h00;
        HOST_D_IN = 32'h00000000;
        WORD_SWAP_VALUE = 32'h00000000;
        TX_DWORD = 32'h00000000;
        TX_VALID = 1'b0;
        RX_WORD = 16'h0000;
        RX_WORD_VALID = 1'b0;
        t_bus32();
        t_wr16();
        t_wr_repeat();
        t_rd16();
        t_txrx();
        test_done();
    end
endmodule : host_bus_width_word_swap_test

`default_nettype wire

//--- verification/host_core_model.sv
// Register and FIFO store behind the port, answering within the cycle of each fetch.
// Assumes CORE_ADDR and CORE_WDATA are valid with their pulses.
`default_nettype none

module host_core_model (
    input wire logic SYS_CLK,
    input wire logic CORE_WR,
    input wire logic CORE_RD,
    input wire logic [7:2] CORE_ADDR,
    input wire logic [31:0] CORE_WDATA,
    output logic [31:0] CORE_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] mem_ff [64];
    logic [31:0] noise_ff;

    initial begin
        for (int i = 0; i < 64; i++) begin
            mem_ff[i] = 32'h5a5a0000 | i;
        end
        noise_ff = 32'h00000000;
    end

    always @(posedge SYS_CLK) begin
        if (CORE_WR) begin
            mem_ff[CORE_ADDR] <= CORE_WDATA;
        end
        noise_ff <= ~noise_ff;
    end

    // The port samples read data at the edge that ends its CORE_RD cycle, so the answer is combinational.
    // Outside that cycle toggling junk is shown, so a late sample can never look right.
    assign CORE_RDATA = CORE_RD ? mem_ff[CORE_ADDR] : noise_ff;
endmodule : host_core_model

`default_nettype wire
